/* design/esu_cfg.svh */
`ifndef ESU_CFG_SVH
`define ESU_CFG_SVH
`define ESU_DATA_W 8
`define ESU_SEL_W 2
`define ESU_ENG_N 3
`define ESU_VAR_RST 8'h00
`define ESU_SEL_A 2'h0
`define ESU_SEL_B 2'h1
`define ESU_SEL_C 2'h2
`define ESU_SEL_REG 2'h3
`endif

/* design/esu_pkg.sv */
package esu_pkg;
  typedef logic [7:0] esu_byte_t;
  typedef logic [1:0] esu_sel_t;
  typedef logic [1:0] esu_eng_t;
endpackage

/* design/esu_op_if.sv */
`timescale 1ns/1ps
interface esu_op_if;
  logic imm_form;
  esu_pkg::esu_byte_t imm;
  esu_pkg::esu_byte_t opa;
  esu_pkg::esu_byte_t opb;
  esu_pkg::esu_byte_t diff;
  modport core (input imm_form, input imm, input opa, input opb, output diff);
  modport ctrl (output imm_form, output imm, output opa, output opb, input diff);
endinterface

/* design/esu_sub_core.sv */
`timescale 1ns/1ps
module esu_sub_core (
  esu_op_if.core op
);
  // Minuend is the target in immediate form, first source otherwise.
  always_comb begin
    if (op.imm_form) begin
      op.diff = op.opa - op.imm;
    end else begin
      op.diff = op.opa - op.opb;
    end
  end
endmodule

/* design/esu_engine_subtract_unit.sv */
`timescale 1ns/1ps
`include "esu_cfg.svh"
module esu_engine_subtract_unit (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Instruction.
  input wire logic i_exec,
  input wire esu_pkg::esu_eng_t i_engine,
  input wire logic i_imm_form,
  input wire esu_pkg::esu_byte_t i_imm,
  input wire esu_pkg::esu_sel_t i_target,
  input wire esu_pkg::esu_sel_t i_src1,
  input wire esu_pkg::esu_sel_t i_src2,
  // Register-held operand.
  input wire esu_pkg::esu_byte_t i_reg_value,
  // Variables and completion.
  output logic [23:0] o_var_a,
  output logic [23:0] o_var_b,
  output esu_pkg::esu_byte_t o_var_c,
  output logic o_done
);
  typedef struct packed {
    logic [2:0][7:0] a;
    logic [2:0][7:0] b;
    logic [7:0] c;
    logic done;
  } esu_state_t;

  esu_state_t st_q;
  esu_state_t st_d;
  esu_op_if op ();

  // Shared decode for both source fields and the target read.
  // Engine code 3 indexes past the arrays here; the write logic never keeps that result.
  function automatic esu_pkg::esu_byte_t pick(input esu_state_t s, input esu_pkg::esu_sel_t sel,
                                              input esu_pkg::esu_eng_t e,
                                              input esu_pkg::esu_byte_t rv);
    if (sel == `ESU_SEL_A) begin
      pick = s.a[e];
    end else if (sel == `ESU_SEL_B) begin
      pick = s.b[e];
    end else if (sel == `ESU_SEL_C) begin
      pick = s.c;
    end else begin
      pick = rv;
    end
  endfunction

  esu_sub_core u_core (
    .op(op)
  );

  // Immediate form reads only the target; variable form ignores the constant.
  always_comb begin
    op.imm_form = i_imm_form;
    op.imm = i_imm;
    op.opa = i_imm_form ? pick(st_q, i_target, i_engine, i_reg_value)
                        : pick(st_q, i_src1, i_engine, i_reg_value);
    op.opb = pick(st_q, i_src2, i_engine, i_reg_value);
  end

  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    // Engine code 3 and target code 3 are not legal; neither changes a variable, but target code 3 still pulses done.
    if (i_exec && i_engine < 2'(`ESU_ENG_N)) begin
      st_d.done = 1'b1;
      // Only eight bits of the difference are kept, so a borrow past zero wraps to 255.
      if (i_target == `ESU_SEL_A) begin
        st_d.a[i_engine] = op.diff;
      end else if (i_target == `ESU_SEL_B) begin
        st_d.b[i_engine] = op.diff;
      end else if (i_target == `ESU_SEL_C) begin
        st_d.c = op.diff;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      // Every variable, in every engine, starts from the same cleared value.
      st_q.a <= {3{`ESU_VAR_RST}};
      st_q.b <= {3{`ESU_VAR_RST}};
      st_q.c <= `ESU_VAR_RST;
      st_q.done <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_var_a = st_q.a;
  assign o_var_b = st_q.b;
  assign o_var_c = st_q.c;
  assign o_done = st_q.done;

  function automatic logic [7:0] old_val(input logic [23:0] va, input logic [23:0] vb,
                                         input logic [7:0] vc, input logic [1:0] sel,
                                         input logic [1:0] e, input logic [7:0] rv);
    if (sel == 2'h0) begin
      old_val = va[8*e +: 8];
    end else if (sel == 2'h1) begin
      old_val = vb[8*e +: 8];
    end else if (sel == 2'h2) begin
      old_val = vc;
    end else begin
      old_val = rv;
    end
  endfunction

  sequence exec_c_s;
    i_exec && i_engine != 2'h3 && i_target == 2'h2;
  endsequence

  imm_sub_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    exec_c_s and i_imm_form |=> o_var_c == 8'($past(o_var_c) - $past(i_imm)))
    else $error("immediate subtract result wrong");

  var_sub_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    exec_c_s and !i_imm_form |=> o_var_c == 8'(
      old_val($past(o_var_a), $past(o_var_b), $past(o_var_c), $past(i_src1),
              $past(i_engine), $past(i_reg_value)) -
      old_val($past(o_var_a), $past(o_var_b), $past(o_var_c), $past(i_src2),
              $past(i_engine), $past(i_reg_value))))
    else $error("variable subtract result wrong");

  wrap_low_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    exec_c_s and i_imm_form and o_var_c == 8'h00 and i_imm == 8'h01 |=> o_var_c == 8'hFF)
    else $error("subtract did not wrap to 255");

  reg_src_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    exec_c_s and !i_imm_form and i_src1 == 2'h3 and i_src2 == 2'h2
    |=> o_var_c == 8'($past(i_reg_value) - $past(o_var_c)))
    else $error("register operand not used");

  local_b_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_exec && i_engine == 2'h1 && i_target == 2'h1 && !i_imm_form && i_src2 == 2'h3
    && i_src1 == 2'h1 |=> o_var_b[15:8] == 8'($past(o_var_b[15:8]) - $past(i_reg_value)))
    else $error("source decode of B wrong");

  imm_ignores_src_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_exec && i_engine == 2'h0 && i_target == 2'h0 && i_imm_form
    |=> o_var_a[7:0] == 8'($past(o_var_a[7:0]) - $past(i_imm)))
    else $error("immediate form used source fields");

  private_vars_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_exec && i_engine == 2'h0 && i_target != 2'h2
    |=> $stable(o_var_a[23:8]) && $stable(o_var_b[23:8]) && $stable(o_var_c))
    else $error("other engine variables disturbed");

  single_update_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_exec |=> !o_done && $stable(o_var_a) && $stable(o_var_b) && $stable(o_var_c))
    else $error("variable changed without instruction");

  // The properties below cover every engine and target, not just the shared variable.
  sequence exec_any_s;
    i_exec && i_engine != 2'h3;
  endsequence

  sequence exec_write_s;
    i_exec && i_engine != 2'h3 && i_target != 2'h3;
  endsequence

  sequence vars_held_s;
    $stable(o_var_a) && $stable(o_var_b) && $stable(o_var_c);
  endsequence

  done_pulse_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    exec_any_s |=> o_done)
    else $error("accepted subtract gave no completion pulse");

  done_cause_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_done |-> $past(i_exec) && $past(i_engine) != 2'h3)
    else $error("completion pulse without accepted subtract");

  any_imm_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    exec_write_s and i_imm_form
    |=> old_val(o_var_a, o_var_b, o_var_c, $past(i_target), $past(i_engine), 8'h00)
        == 8'(old_val($past(o_var_a), $past(o_var_b), $past(o_var_c), $past(i_target),
                      $past(i_engine), 8'h00) - $past(i_imm)))
    else $error("immediate subtract into target wrong");

  any_var_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    exec_write_s and !i_imm_form
    |=> old_val(o_var_a, o_var_b, o_var_c, $past(i_target), $past(i_engine), 8'h00)
        == 8'(old_val($past(o_var_a), $past(o_var_b), $past(o_var_c), $past(i_src1),
                      $past(i_engine), $past(i_reg_value)) -
              old_val($past(o_var_a), $past(o_var_b), $past(o_var_c), $past(i_src2),
                      $past(i_engine), $past(i_reg_value))))
    else $error("variable subtract into target wrong");

  no_target_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    exec_any_s and i_target == 2'h3 |=> o_done ##0 vars_held_s)
    else $error("target code 3 changed a variable");

  bad_engine_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_exec && i_engine == 2'h3 |=> !o_done ##0 vars_held_s)
    else $error("engine code 3 was executed");

  own_a_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_exec && i_engine == 2'h2 && i_target == 2'h0
    |=> $stable(o_var_a[15:0]) && $stable(o_var_b) && $stable(o_var_c))
    else $error("engine 2 write to A disturbed other variables");

  own_b_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_exec && i_engine == 2'h1 && i_target == 2'h1
    |=> $stable(o_var_a) && $stable(o_var_b[23:16]) && $stable(o_var_b[7:0])
        && $stable(o_var_c))
    else $error("engine 1 write to B disturbed other variables");

  shared_c_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_exec && i_engine == 2'h1 && i_target == 2'h2 && i_imm_form
    |=> o_var_c == 8'($past(o_var_c) - $past(i_imm)))
    else $error("engine 1 did not reach the shared variable");

  reg_pair_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    exec_write_s and !i_imm_form and i_src1 == 2'h3 and i_src2 == 2'h3
    |=> old_val(o_var_a, o_var_b, o_var_c, $past(i_target), $past(i_engine), 8'h00) == 8'h00)
    else $error("register operand minus itself not zero");

  self_src_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    exec_write_s and !i_imm_form and i_src1 == i_target and i_src2 == 2'h3
    |=> old_val(o_var_a, o_var_b, o_var_c, $past(i_target), $past(i_engine), 8'h00)
        == 8'(old_val($past(o_var_a), $past(o_var_b), $past(o_var_c), $past(i_target),
                      $past(i_engine), 8'h00) - $past(i_reg_value)))
    else $error("self-referencing subtract did not use the old value");
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_exec = 1'b0;
  logic i_imm_form = 1'b0;
  esu_pkg::esu_eng_t i_engine = 2'h0;
  esu_pkg::esu_byte_t i_imm = 8'h00;
  esu_pkg::esu_byte_t i_reg_value = 8'h00;
  esu_pkg::esu_sel_t i_target = 2'h0;
  esu_pkg::esu_sel_t i_src1 = 2'h0;
  esu_pkg::esu_sel_t i_src2 = 2'h0;
  logic [23:0] o_var_a;
  logic [23:0] o_var_b;
  esu_pkg::esu_byte_t o_var_c;
  logic o_done;
  logic [7:0] ma [3] = '{default: 8'h00};
  logic [7:0] mb [3] = '{default: 8'h00};
  logic [7:0] mc = 8'h00;
  logic [55:0] notes [$];
  int num_errors = 0;
  int comparisons = 0;
  esu_engine_subtract_unit u_esu_engine_subtract_unit (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_exec(i_exec), .i_engine(i_engine), .i_imm_form(i_imm_form), .i_imm(i_imm),
    .i_target(i_target), .i_src1(i_src1), .i_src2(i_src2), .i_reg_value(i_reg_value),
    .o_var_a(o_var_a), .o_var_b(o_var_b), .o_var_c(o_var_c), .o_done(o_done));
  initial forever #50 i_ref_clk = ~i_ref_clk;
  task automatic check(input logic [55:0] seen, input logic [55:0] want);
    comparisons++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [7:0] pick(input logic [1:0] s, input logic [1:0] e);
    case (s)
      2'h0: return ma[e];
      2'h1: return mb[e];
      2'h2: return mc;
      default: return i_reg_value;
    endcase
  endfunction
  // Expected results are noted at issue time, so back-to-back operations see prior updates.
  task automatic issue(input logic [1:0] e, input logic f, input logic [7:0] k,
                       input logic [1:0] t, input logic [1:0] s1, input logic [1:0] s2,
                       input logic [7:0] rv);
    logic [7:0] r;
    @(posedge i_ref_clk);
    #1;
    i_exec = 1'b1;
    i_engine = e;
    i_imm_form = f;
    i_imm = k;
    i_target = t;
    i_src1 = s1;
    i_src2 = s2;
    i_reg_value = rv;
    if (e != 2'h3) begin
      r = f ? pick(t, e) - k : pick(s1, e) - pick(s2, e);
      if (t == 2'h0) ma[e] = r;
      else if (t == 2'h1) mb[e] = r;
      else if (t == 2'h2) mc = r;
      notes.push_back({ma[2], ma[1], ma[0], mb[2], mb[1], mb[0], mc});
    end
  endtask
  always @(negedge i_ref_clk) begin
    if (o_done === 1'b1) begin
      if (notes.size() == 0) check({o_var_a, o_var_b, o_var_c}, 56'h0 - 56'h1);
      else check({o_var_a, o_var_b, o_var_c}, notes.pop_front());
    end else if (!i_rst) begin
      check(56'(o_done), 56'h0);
    end
  end
  initial begin
    void'($urandom(78666));
    repeat (10) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    check({o_var_a, o_var_b, o_var_c}, 56'h0);
    issue(2'h0, 1'b1, 8'h05, 2'h2, 2'h0, 2'h0, 8'h00);
    issue(2'h1, 1'b0, 8'hAA, 2'h0, 2'h2, 2'h3, 8'h10);
    issue(2'h2, 1'b0, 8'h00, 2'h2, 2'h2, 2'h0, 8'h00);
    issue(2'h0, 1'b1, 8'hFB, 2'h2, 2'h0, 2'h0, 8'h00);
    issue(2'h1, 1'b1, 8'h01, 2'h2, 2'h0, 2'h0, 8'h00);
    issue(2'h2, 1'b0, 8'h00, 2'h2, 2'h3, 2'h2, 8'h33);
    issue(2'h1, 1'b0, 8'h00, 2'h1, 2'h1, 2'h3, 8'h44);
    issue(2'h3, 1'b1, 8'h01, 2'h0, 2'h0, 2'h0, 8'h00);
    issue(2'h0, 1'b1, 8'h01, 2'h3, 2'h0, 2'h0, 8'h00);
    repeat (300) begin
      issue(2'($urandom), 1'($urandom), 8'($urandom), 2'($urandom), 2'($urandom),
            2'($urandom), 8'($urandom));
    end
    @(posedge i_ref_clk);
    #1;
    i_exec = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    check(56'(notes.size()), 56'h0);
    conclude();
  end
  // The full sequence needs about 320 cycles; this bound leaves ample margin.
  initial begin
    #1000000;
    num_errors++;
    conclude();
  end
endmodule
